// >>> dscd_top.sv
// Command decoder for a single-channel 16-bit converter.
// Assumes the link pins and the three control pins are asynchronous
// to i_clk; every control and status bit is a plain port.
`timescale 1ns/1ps

// Overview of operation
// - Only channel zero acts; others ignored
// - Channel address in command bits two..zero
// - Config commands pick channels by payload mask
// - Restore command returns registers to defaults
// - Apply command copies staged into output
// - Hold select: one blocks, default blocks
// - Sleep: upper hiz, lower pulldown, default off
// - Both sleep bits set gives pulldown
// - Write goes by hold select
// - Store-and-apply loads staged and output
// - Broadcast loads staged and output always
// - Write-through updates output at frame end
// - Low apply pin copies staged to output
// - Low zero pin forces strap level
// - Commands still work while asleep
module dscd_top
  import dscd_pkg::*;
#(
  parameter int DATA_W = DSCD_DATA_W
)
(
  // System
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial link
  input wire logic i_sclk,
  input wire logic i_frame_select_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // Control pins
  input wire logic i_apply_pin_n,
  input wire logic i_zero_pin_n,
  input wire logic i_startup_level_pin,
  // Converter state
  output logic [DATA_W-1:0] o_output_value,
  output logic [DATA_W-1:0] o_staged_value,
  output logic o_write_block,
  output logic o_hiz_sleep,
  output logic o_pulldown_output_sel
);

  // True when a channel field addresses the one real channel
  function automatic logic is_ch0(input logic [7:0] cmd);
    is_ch0 = cmd[2:0] == DSCD_CH0_ADDR;
  endfunction

  // Five-bit prefix of a command byte
  function automatic logic [4:0] pfx(input logic [7:0] cmd);
    pfx = cmd[7:3];
  endfunction

  // Control pin synchronisers: apply, zero, startup
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_s_r;
  logic apply_n_s, zero_n_s, startup_s;

  assign pin_in = {i_startup_level_pin, i_zero_pin_n, i_apply_pin_n};

  // Each pin passes two flops; the first is read only by the second
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          pin_meta_r[g] <= 1'b1;
          pin_s_r[g] <= 1'b1;
        end else begin
          pin_meta_r[g] <= pin_in[g];
          pin_s_r[g] <= pin_meta_r[g];
        end
      end
    end
  endgenerate

  assign apply_n_s = pin_s_r[0];
  assign zero_n_s = pin_s_r[1];
  assign startup_s = pin_s_r[2];

  // Receiver outputs
  logic cmd_valid;
  logic [7:0] cmd_early;
  logic frame_valid;
  dscd_frame_t frame;
  logic rd_load;
  logic sdo_w, sdo_oe_w;

  // Converter registers and their next values
  logic [DATA_W-1:0] staged_r, staged_nxt;
  logic [DATA_W-1:0] output_r, output_nxt;
  dscd_cfg_t cfg_r, cfg_nxt;
  logic hiz_r, hiz_nxt;
  logic pull_r, pull_nxt;
  logic [1:0] init_r, init_nxt;
  logic [DATA_W-1:0] def_level;

  // Strap decides the power-up and clear level
  assign def_level = startup_s ? DATA_W'(DSCD_MID_LEVEL) :
                                 DATA_W'(DSCD_ZERO_LEVEL);

  // Readback starts once the command byte is in
  assign rd_load = cmd_valid && is_ch0(cmd_early) &&
                   pfx(cmd_early) == DSCD_STAGED_READBACK_PFX;

  // Frame receiver and readback shifter
  dscd_spi_rx u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sclk(i_sclk),
    .i_frame_select_n(i_frame_select_n),
    .i_sdi(i_sdi),
    .i_rd_load(rd_load),
    .i_rd_word(staged_r[DATA_W-1 -: DSCD_DATA_W]),
    .o_cmd_valid(cmd_valid),
    .o_cmd(cmd_early),
    .o_frame_valid(frame_valid),
    .o_frame(frame),
    .o_sdo(sdo_w),
    .o_sdo_oe(sdo_oe_w)
  );

  // Command execution and pin overrides
  always_comb begin
    staged_nxt = staged_r;
    output_nxt = output_r;
    cfg_nxt = cfg_r;
    init_nxt = init_r;
    // Strap is trusted only once its synchroniser has settled
    if (init_r != 2'h0) begin
      init_nxt = init_r - 2'h1;
      if (init_r == 2'h1) begin
        staged_nxt = def_level;
        output_nxt = def_level;
      end
    end
    // Frames are decoded whatever the sleep state
    if (frame_valid) begin
      if (frame.cmd == DSCD_ZERO_RESTORE_CMD) begin
        // Payload ignored; everything back to power-up state
        staged_nxt = def_level;
        output_nxt = def_level;
        cfg_nxt.write_block = DSCD_HOLD_SEL_RST;
        cfg_nxt.pd_hiz = DSCD_SLEEP_RST;
        cfg_nxt.pd_pull = DSCD_SLEEP_RST;
      end else if (frame.cmd == DSCD_APPLY_PRELOAD_CMD) begin
        // Mask bit zero selects the real channel
        if (frame.payload[DSCD_CH0_LO_BIT]) begin
          output_nxt = staged_r;
        end
      end else if (frame.cmd == DSCD_HOLD_SEL_CMD) begin
        // Other mask bits have no channel behind them
        cfg_nxt.write_block = frame.payload[DSCD_CH0_LO_BIT];
      end else if (frame.cmd == DSCD_SLEEP_CMD) begin
        cfg_nxt.pd_hiz = frame.payload[DSCD_CH0_HI_BIT];
        cfg_nxt.pd_pull = frame.payload[DSCD_CH0_LO_BIT];
      end else if (frame.cmd == DSCD_BROADCAST_STORE_CMD) begin
        staged_nxt = frame.payload;
        output_nxt = frame.payload;
      end else if (is_ch0(frame.cmd)) begin
        if (pfx(frame.cmd) == DSCD_WRITE_PFX) begin
          // Hold select picks the destination
          staged_nxt = frame.payload;
          if (!cfg_r.write_block) begin
            output_nxt = frame.payload;
          end
        end else if (pfx(frame.cmd) == DSCD_STORE_AND_APPLY_PFX) begin
          staged_nxt = frame.payload;
          output_nxt = frame.payload;
        end
      end
      // Idle, reserved, readback and other channels fall through
      // with no register change
    end
    // Level-sensitive apply pin, after any write of this cycle
    if (!apply_n_s) begin
      output_nxt = staged_nxt;
    end
    // Clear pin wins over every other source of the output
    if (!zero_n_s) begin
      output_nxt = def_level;
    end
    // Both sleep bits mean pulldown, never floating
    pull_nxt = cfg_nxt.pd_pull;
    hiz_nxt = cfg_nxt.pd_hiz && !cfg_nxt.pd_pull;
  end

  // Register converter state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      staged_r <= '0;
      output_r <= '0;
      cfg_r <= '{write_block: DSCD_HOLD_SEL_RST,
                 pd_hiz: DSCD_SLEEP_RST,
                 pd_pull: DSCD_SLEEP_RST};
      hiz_r <= DSCD_SLEEP_RST;
      pull_r <= DSCD_SLEEP_RST;
      init_r <= DSCD_STRAP_WAIT;
    end else begin
      staged_r <= staged_nxt;
      output_r <= output_nxt;
      cfg_r <= cfg_nxt;
      hiz_r <= hiz_nxt;
      pull_r <= pull_nxt;
      init_r <= init_nxt;
    end
  end

  // Outputs straight from flops
  assign o_output_value = output_r;
  assign o_staged_value = staged_r;
  assign o_write_block = cfg_r.write_block;
  assign o_hiz_sleep = hiz_r;
  assign o_pulldown_output_sel = pull_r;
  assign o_sdo = sdo_w;
  assign o_sdo_oe = sdo_oe_w;

  // Checks, all in the system clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Pins idle and strap settled: only frames move the data
  logic quiet;
  assign quiet = apply_n_s && zero_n_s && init_r == 2'h0;

  // Plain write to channel zero with the pins idle
  logic wr_ch0;
  assign wr_ch0 = frame_valid && quiet && is_ch0(frame.cmd) &&
                  pfx(frame.cmd) == DSCD_WRITE_PFX;

  write_block_a: assert property (
    wr_ch0 && cfg_r.write_block |=>
    staged_r == $past(frame.payload) && $stable(output_r))
    else $error("blocked write reached the output");

  write_thru_a: assert property (
    wr_ch0 && !cfg_r.write_block |=>
    output_r == $past(frame.payload) && staged_r == output_r)
    else $error("write-through missed the output");

  store_apply_a: assert property (
    frame_valid && quiet && is_ch0(frame.cmd) &&
    pfx(frame.cmd) == DSCD_STORE_AND_APPLY_PFX |=>
    output_r == $past(frame.payload) && staged_r == output_r)
    else $error("store-and-apply did not load both");

  broadcast_a: assert property (
    frame_valid && quiet && frame.cmd == DSCD_BROADCAST_STORE_CMD |=>
    output_r == $past(frame.payload) && staged_r == output_r)
    else $error("broadcast did not load both");

  other_chan_a: assert property (
    frame_valid && quiet && !is_ch0(frame.cmd) &&
    frame.cmd != DSCD_ZERO_RESTORE_CMD &&
    frame.cmd[7] == 1'b0 && frame.cmd[5:4] == 2'h0 |=>
    $stable(staged_r) && $stable(output_r))
    else $error("other channel changed the data");

  reserved_cmd_a: assert property (
    frame_valid && quiet && pfx(frame.cmd) == DSCD_RESERVED_PFX |=>
    $stable(staged_r) && $stable(output_r) && $stable(cfg_r))
    else $error("reserved command changed state");

  hold_sel_a: assert property (
    frame_valid && frame.cmd == DSCD_HOLD_SEL_CMD |=>
    o_write_block == $past(frame.payload[DSCD_CH0_LO_BIT]))
    else $error("hold select not taken");

  sleep_prio_a: assert property (
    frame_valid && frame.cmd == DSCD_SLEEP_CMD &&
    frame.payload[DSCD_CH0_HI_BIT] && frame.payload[DSCD_CH0_LO_BIT]
    |=> o_pulldown_output_sel && !o_hiz_sleep)
    else $error("both sleep bits did not give pulldown");

  restore_a: assert property (
    frame_valid && zero_n_s && frame.cmd == DSCD_ZERO_RESTORE_CMD |=>
    cfg_r.write_block && !cfg_r.pd_hiz && !cfg_r.pd_pull &&
    staged_r == def_level)
    else $error("restore left a register changed");

  zero_pin_a: assert property (
    !zero_n_s |=> output_r == $past(def_level))
    else $error("clear pin did not force the level");

  apply_pin_a: assert property (
    !apply_n_s && zero_n_s |=> output_r == staged_r)
    else $error("apply pin did not copy staged");

  // Main scenarios
  cov_block_then_apply: cover property (
    wr_ch0 && cfg_r.write_block ##[1:200]
    frame_valid && frame.cmd == DSCD_APPLY_PRELOAD_CMD);
  cov_readback: cover property (rd_load ##[1:200] o_sdo_oe);
  cov_sleep_write: cover property (
    (o_hiz_sleep || o_pulldown_output_sel) && wr_ch0);

endmodule

// >>> dscd_pkg.sv
// Shared constants and carriers for the serial command decoder.
// Assumes a single 10 MHz system clock domain; the link is sampled.
package dscd_pkg;

  // Widths of the serial frame
  localparam int DSCD_CMD_W = 8;
  localparam int DSCD_DATA_W = 16;
  localparam int DSCD_FRAME_W = 24;
  localparam logic [4:0] DSCD_CMD_BITS = 5'h08;
  localparam logic [4:0] DSCD_FRAME_BITS = 5'h18;

  // Full command bytes
  localparam logic [7:0] DSCD_IDLE_CMD = 8'h00;
  localparam logic [7:0] DSCD_ZERO_RESTORE_CMD = 8'h01;
  localparam logic [7:0] DSCD_APPLY_PRELOAD_CMD = 8'h18;
  localparam logic [7:0] DSCD_HOLD_SEL_CMD = 8'h28;
  localparam logic [7:0] DSCD_SLEEP_CMD = 8'h30;
  localparam logic [7:0] DSCD_BROADCAST_STORE_CMD = 8'h20;

  // Five-bit prefixes of commands that carry a channel field
  localparam logic [4:0] DSCD_WRITE_PFX = 5'h01;
  localparam logic [4:0] DSCD_STORE_AND_APPLY_PFX = 5'h02;
  localparam logic [4:0] DSCD_RESERVED_PFX = 5'h10;
  localparam logic [4:0] DSCD_STAGED_READBACK_PFX = 5'h11;

  // Channel zero positions inside the payload and channel field
  localparam int DSCD_CH0_LO_BIT = 0;
  localparam int DSCD_CH0_HI_BIT = 8;
  localparam logic [2:0] DSCD_CH0_ADDR = 3'h0;

  // Power-up defaults
  localparam logic DSCD_HOLD_SEL_RST = 1'h1;
  localparam logic DSCD_SLEEP_RST = 1'h0;
  localparam logic [15:0] DSCD_ZERO_LEVEL = 16'h0000;
  localparam logic [15:0] DSCD_MID_LEVEL = 16'h8000;

  // Cycles after reset release before the startup strap is trusted
  localparam logic [1:0] DSCD_STRAP_WAIT = 2'h3;

  // One received frame
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] payload;
  } dscd_frame_t;

  // Channel zero configuration
  typedef struct packed {
    logic write_block;
    logic pd_hiz;
    logic pd_pull;
  } dscd_cfg_t;

endpackage

// >>> dscd_spi_rx.sv
// Serial frame receiver: samples the link pins on the system clock,
// assembles 24-bit frames and shifts readback data out.
// Assumes the link clock is at least four system clocks per half period.
`timescale 1ns/1ps

module dscd_spi_rx
  import dscd_pkg::*;
(
  // System
  input wire logic i_clk,
  input wire logic i_rst,
  // Link pins, asynchronous to i_clk
  input wire logic i_sclk,
  input wire logic i_frame_select_n,
  input wire logic i_sdi,
  // Readback word, loaded by a one-cycle pulse
  input wire logic i_rd_load,
  input wire logic [15:0] i_rd_word,
  // Decoded results
  output logic o_cmd_valid,
  output logic [7:0] o_cmd,
  output logic o_frame_valid,
  output dscd_frame_t o_frame,
  output logic o_sdo,
  output logic o_sdo_oe
);

  // Idle pin levels {sdi, select, link clock}: the link clock rests low,
  // so a reset value of one would fake a falling edge on release
  localparam logic [2:0] PIN_IDLE = 3'h2;

  // Two-flop synchronisers plus one history stage per pin
  logic [2:0] meta_r, sync_r, hist_r;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, cs_low;

  // Frame state
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic rd_act_r, rd_act_nxt;
  logic sdo_r, sdo_nxt;
  logic cmdv_r, cmdv_nxt, frv_r, frv_nxt;

  // Synchronise; only sync_r reads meta_r
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= PIN_IDLE;
      sync_r <= PIN_IDLE;
      hist_r <= PIN_IDLE;
    end else begin
      meta_r <= {i_sdi, i_frame_select_n, i_sclk};
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  // Edges of the sampled link clock and select
  assign sclk_rise = sync_r[0] && !hist_r[0];
  assign sclk_fall = !sync_r[0] && hist_r[0];
  assign cs_rise = sync_r[1] && !hist_r[1];
  assign cs_fall = !sync_r[1] && hist_r[1];
  assign cs_low = !sync_r[1];

  // Next state of the frame shifter
  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    rd_act_nxt = rd_act_r;
    sdo_nxt = sdo_r;
    cmdv_nxt = 1'b0;
    frv_nxt = 1'b0;
    if (cs_fall) begin
      // New frame: bit count restarts, readback ends
      cnt_nxt = '0;
      rd_act_nxt = 1'b0;
    end else if (cs_low && sclk_rise) begin
      // Data taken on the rising link edge; long frames keep last 24
      sh_nxt = {sh_r[22:0], sync_r[2]};
      if (cnt_r != DSCD_FRAME_BITS) begin
        cnt_nxt = cnt_r + 5'h01;
      end
      cmdv_nxt = (cnt_r + 5'h01) == DSCD_CMD_BITS;
    end
    if (i_rd_load) begin
      rd_nxt = i_rd_word;
      rd_act_nxt = 1'b1;
    end else if (rd_act_r && cs_low && sclk_fall) begin
      // Present the next bit, most significant first
      sdo_nxt = rd_r[15];
      rd_nxt = {rd_r[14:0], 1'b0};
    end
    if (cs_rise) begin
      // Short frames are dropped, full ones are executed
      frv_nxt = cnt_r == DSCD_FRAME_BITS;
      rd_act_nxt = 1'b0;
    end
  end

  // Register the frame state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      sh_r <= '0;
      rd_r <= '0;
      rd_act_r <= 1'b0;
      sdo_r <= 1'b0;
      cmdv_r <= 1'b0;
      frv_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      rd_act_r <= rd_act_nxt;
      sdo_r <= sdo_nxt;
      cmdv_r <= cmdv_nxt;
      frv_r <= frv_nxt;
    end
  end

  assign o_cmd_valid = cmdv_r;
  assign o_cmd = sh_r[7:0];
  assign o_frame_valid = frv_r;
  assign o_frame = sh_r;
  assign o_sdo = sdo_r;
  assign o_sdo_oe = rd_act_r;

  // Readback drive stays inside the frame
  rb_in_frame_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    rd_act_r && cs_rise |=> !rd_act_r)
    else $error("readback drive outlived the frame");

endmodule

// >>> dscd_spi_ctrl.sv
// Controller model for the decoder's serial link: mode 0, MSB first.
// Assumes a 100 ns system clock; a link half period is four clocks.
`timescale 1ns/1ps

module dscd_spi_ctrl (
  // Pacing clock
  input wire logic i_clk,
  // Link pins
  output logic o_sclk,
  output logic o_frame_select_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  // Link clock stands still low and select is idle between frames
  initial begin
    o_sclk = 1'b0;
    o_frame_select_n = 1'b1;
    o_sdi = 1'b0;
  end

  // Shift the top nbits of word out; readback is caught on rising edges
  task automatic xfer(input logic [23:0] word, input int nbits,
                      output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    @(negedge i_clk);
    o_frame_select_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      // Data set up half a link period before the rising edge
      o_sdi = word[23-i];
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      // Payload slots carry the readback word
      if (i >= 8) begin
        rd = {rd[14:0], i_sdo};
      end
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_frame_select_n = 1'b1;
    // Released data line must not keep its last value
    o_sdi = ~o_sdi;
    repeat (4) @(negedge i_clk);
  endtask
endmodule

// >>> dscd_top_tb.sv
// Self-checking bench for the serial command decoder top.
// Assumes the controller model paces frames; pins driven on falling edges.
`timescale 1ns/1ps

module dscd_top_tb;
  import dscd_pkg::*;

  // Expected converter state
  typedef struct packed {
    logic [15:0] outv;
    logic [15:0] stg;
    logic wb;
    logic hiz;
    logic pull;
  } dscd_exp_t;

  // Clock, reset, link and control pins
  logic i_clk;
  logic i_rst;
  logic sclk, sel_n, sdi, sdo, sdo_oe;
  logic apply_n, zero_n, strap;
  logic [15:0] out_v, stg_v;
  logic wb, hiz, pull;
  // Bookkeeping
  int err_count;
  int check_count;
  integer seed;
  int i;
  dscd_exp_t exp_s;
  logic [15:0] rd;
  logic [15:0] p;
  logic [7:0] cmds [10];

  // System clock, 100 ns
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  dscd_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
    .i_frame_select_n(sel_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_apply_pin_n(apply_n), .i_zero_pin_n(zero_n),
    .i_startup_level_pin(strap), .o_output_value(out_v),
    .o_staged_value(stg_v), .o_write_block(wb), .o_hiz_sleep(hiz),
    .o_pulldown_output_sel(pull));

  dscd_spi_ctrl u_ctrl (.i_clk(i_clk), .o_sclk(sclk),
    .o_frame_select_n(sel_n), .o_sdi(sdi), .i_sdo(sdo));

  // Level the strap selects
  function automatic logic [15:0] def_lvl(input logic s);
    return s ? 16'h8000 : 16'h0000;
  endfunction

  // Next expected state after one full frame
  function automatic dscd_exp_t model(input dscd_exp_t s,
                                      input logic [23:0] f, input logic st);
    logic [7:0] c;
    c = f[23:16];
    if (c == 8'h01) begin
      s = {def_lvl(st), def_lvl(st), 1'b1, 1'b0, 1'b0};
    end else if (c == 8'h18 && f[0]) begin
      s.outv = s.stg;
    end else if (c == 8'h28) begin
      s.wb = f[0];
    end else if (c == 8'h30) begin
      s.hiz = f[8];
      s.pull = f[0];
    end else if (c == 8'h20 || c == 8'h10) begin
      s.stg = f[15:0];
      s.outv = f[15:0];
    end else if (c == 8'h08) begin
      s.stg = f[15:0];
      if (!s.wb) begin
        s.outv = f[15:0];
      end
    end
    // Anything else, other channels included, leaves the state alone
    return s;
  endfunction

  // One comparison
  task automatic check(input logic [15:0] got, input logic [15:0] ex,
                       input string what);
    check_count++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, ex);
    end
  endtask

  // Every state output against the expected state
  task automatic check_all();
    check(out_v, exp_s.outv, "output");
    check(stg_v, exp_s.stg, "staged");
    check({15'h0, wb}, {15'h0, exp_s.wb}, "hold");
    check({15'h0, pull}, {15'h0, exp_s.pull}, "pulldown");
    check({15'h0, hiz}, {15'h0, exp_s.hiz & ~exp_s.pull}, "hiz");
  endtask

  // Send a frame, then compare once the result has landed
  task automatic send(input logic [23:0] f);
    u_ctrl.xfer(f, 24, rd);
    exp_s = model(exp_s, f, strap);
    repeat (8) @(negedge i_clk);
    check_all();
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog: about five and a half times the expected run
  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    i_rst = 1'b1;
    apply_n = 1'b1;
    zero_n = 1'b1;
    strap = 1'b1;
    err_count = 0;
    check_count = 0;
    seed = 32'h6425;
    cmds = '{8'h01, 8'h08, 8'h18, 8'h28, 8'h30, 8'h20, 8'h10, 8'h88,
             8'h80, 8'h0b};
    repeat (20) @(negedge i_clk);
    exp_s = {16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0};
    check_all();
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    exp_s.outv = def_lvl(strap);
    exp_s.stg = def_lvl(strap);
    check_all();
    $display("test reset done");
    // Walk through the command set, awkward channel masks included
    send(24'h084000);
    send(24'h180040);
    send(24'h180001);
    send(24'h2800fe);
    send(24'h08ffff);
    send(24'h300100);
    send(24'h300101);
    send(24'h081357);
    send(24'h300001);
    send(24'h300000);
    send(24'h280001);
    send(24'h0b1111);
    send(24'h121111);
    send(24'h10abcd);
    send(24'h205a5a);
    send(24'h00ffff);
    for (i = 0; i < 8; i++) begin
      send({5'h10, i[2:0], 16'($random(seed))});
    end
    send(24'h2800fe);
    send(24'h300101);
    send(24'h010000);
    $display("test commands done");
    // Readback of the staged word, then a short frame that must vanish
    send(24'h08c3a5);
    send(24'h880000);
    check(rd, exp_s.stg, "readback");
    // Readback drive must be gone once the frame has closed
    check({15'h0, sdo_oe}, 16'h0000, "readback drive");
    u_ctrl.xfer(24'h08dead, 16, rd);
    repeat (8) @(negedge i_clk);
    check_all();
    $display("test readback done");
    // Control pins: load copies staged, clear forces the strap level
    send(24'h084321);
    apply_n = 1'b0;
    repeat (6) @(negedge i_clk);
    exp_s.outv = exp_s.stg;
    check_all();
    apply_n = 1'b1;
    zero_n = 1'b0;
    repeat (6) @(negedge i_clk);
    check(out_v, 16'h8000, "clear mid");
    strap = 1'b0;
    repeat (6) @(negedge i_clk);
    check(out_v, 16'h0000, "clear zero");
    check(stg_v, exp_s.stg, "clear staged");
    zero_n = 1'b1;
    strap = 1'b1;
    repeat (6) @(negedge i_clk);
    // Releasing the clear pin keeps the last forced level
    exp_s.outv = def_lvl(1'b0);
    check_all();
    send(24'h200777);
    $display("test pins done");
    // Random commands and payloads
    for (i = 0; i < 20; i++) begin
      p = 16'($random(seed));
      send({cmds[$unsigned($random(seed)) % 10], p});
    end
    $display("test random done");
    finish_test();
  end
endmodule
